/* hw/anps_pkg.sv */
// package of constants and types for the partner ability and expansion status block
package anps_pkg;

	// ----------------------------------------
	// register addresses on the management port
	// ----------------------------------------
	localparam logic [4:0] ANPS_REG_PARTNER = 5'h05;
	localparam logic [4:0] ANPS_REG_EXP = 5'h06;
	localparam logic [4:0] ANPS_REG_NP_RX = 5'h08;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [15:0] ANPS_WORD_RST = 16'h0000;
	localparam logic ANPS_LOCAL_NP_RST = 1'b1;

	// ----------------------------------------
	// expansion register field positions
	// ----------------------------------------
	localparam int ANPS_EXP_AN_ABLE = 0;
	localparam int ANPS_EXP_PAGE_RX = 1;
	localparam int ANPS_EXP_LOCAL_NP = 2;
	localparam int ANPS_EXP_LP_NP = 3;
	localparam int ANPS_EXP_PD_FAULT = 4;
	localparam int ANPS_EXP_BASE_PAGE = 5;
	localparam int ANPS_EXP_RSV_BITS = 10;

	// ----------------------------------------
	// page word field positions
	// ----------------------------------------
	localparam int ANPS_PG_NEXT_PAGE = 15;

	// ----------------------------------------
	// selector codes
	// ----------------------------------------
	localparam logic [4:0] ANPS_SEL_8023 = 5'h01;
	localparam logic [4:0] ANPS_SEL_8029 = 5'h02;
	localparam logic [4:0] ANPS_SEL_RSV_LO = 5'h00;
	localparam logic [4:0] ANPS_SEL_RSV_HI = 5'h1F;

	// ----------------------------------------
	// management frame bit counts
	// ----------------------------------------
	localparam logic [5:0] ANPS_PRE_LEN = 6'h20;
	localparam logic [5:0] ANPS_ADDR_LAST = 6'h09;
	localparam logic [5:0] ANPS_DATA_LAST = 6'h0F;

	// management frame states
	typedef enum logic [2:0] {
		ANPS_ST_PRE = 3'b000,
		ANPS_ST_START = 3'b001,
		ANPS_ST_OP = 3'b010,
		ANPS_ST_ADDR = 3'b011,
		ANPS_ST_TA = 3'b100,
		ANPS_ST_DATA = 3'b101
	} anps_mdio_state_t;

endpackage

/* hw/anps_latch_bit.sv */
// latching-high status bit, set wins over clear
`timescale 1ns/1ns
module anps_latch_bit (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic set,
	input wire logic clr,
	output logic q
);

	// ----------------------------------------
	// sticky flag
	// ----------------------------------------

	// held until cleared; a set in the clear cycle survives
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q <= 1'b0;
		end else begin
			q <= set | (q & ~clr);
		end
	end

endmodule

/* hw/anps_status_regs.sv */
// partner ability and expansion status registers behind the management serial port
//
// Function
// - local pause advertisement loads from its strap pin at reset
// - four local technology advertisement bits load from indicator straps at reset
// - partner ability register is read-only; top bit is partner next page
// - partner acknowledge bit reads 1 once partner received our code word
// - partner asymmetric and symmetric pause bits reflect partner advertisement
// - partner technology bits reflect received base page abilities
// - partner selector field returns the received five-bit selector
// - reserved or unspecified selector codes are never transmitted
// - base page flag latches high, used only with alternate next page feature
// - parallel detection fault flag latches high on a fault
// - expansion bit shows partner next page ability
// - expansion bit shows local next page ability, 1 after reset
// - new page stored into base or next page register, flag set in the same cycle
// - reading expansion register clears page received flag
// - with alternate feature, flag also clears on no page rx or tx disable
// - expansion bit shows partner is auto-negotiation able
// - next pages land in separate read-only register; top bit more pages
`timescale 1ns/1ns
module anps_status_regs
	import anps_pkg::*;
#(
	parameter logic LOCAL_NP_ABLE = ANPS_LOCAL_NP_RST,
	parameter logic [4:0] LOCAL_SEL = ANPS_SEL_8023
) (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic MDC,
	input wire logic MDIO_IN,
	output logic MDIO_OUT,
	output logic MDIO_OE,
	input wire logic [4:0] PHY_ADDR,
	input wire logic PAUSE_STRAP,
	input wire logic [3:0] TECH_STRAP,
	output logic LOCAL_PAUSE_ADV,
	output logic [3:0] LOCAL_TECH_ADV,
	output logic [4:0] LOCAL_SELECTOR,
	input wire logic RX_PAGE_VALID,
	input wire logic RX_PAGE_IS_BASE,
	input wire logic [15:0] RX_PAGE_WORD,
	input wire logic NEG_BASE_PAGE,
	input wire logic PD_FAULT,
	input wire logic PARTNER_AN_ABLE,
	input wire logic MR_PAGE_RX,
	input wire logic TRANSMIT_DISABLE,
	input wire logic ALT_NP_FEATURE
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic mdc_q;
	logic mdc_rise;
	anps_mdio_state_t state_q;
	logic [5:0] cnt_q;
	logic op_hi_q;
	logic op_rd_q;
	logic [9:0] addr_q;
	logic [15:0] shift_q;
	logic [15:0] lp_base_q;
	logic [15:0] lp_np_q;
	logic [15:0] exp_word;
	logic [15:0] rd_word;
	logic phy_hit;
	logic exp_rd_clr;
	logic page_rx_clr;
	logic page_rx_flag;
	logic pd_fault_flag;
	logic base_page_flag;
	logic lp_np_able;

	// ----------------------------------------
	// local advertisement straps
	// ----------------------------------------

	// pause strap load
	// straps are sampled on every reset cycle and frozen on release
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			LOCAL_PAUSE_ADV <= PAUSE_STRAP;
		end
	end

	// technology strap load
	// order is 100 full, 100 half, 10 full, 10 half
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			LOCAL_TECH_ADV <= TECH_STRAP;
		end
	end

	// legal selector only
	// a reserved or unspecified parameter falls back to 802.3
	always_comb begin
		if (LOCAL_SEL == ANPS_SEL_8023 || LOCAL_SEL == ANPS_SEL_8029) begin
			LOCAL_SELECTOR = LOCAL_SEL;
		end else begin
			LOCAL_SELECTOR = ANPS_SEL_8023;
		end
	end

	// ----------------------------------------
	// received page storage
	// ----------------------------------------

	// base page store
	// base page word kept whole; returned unchanged on read
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			lp_base_q <= ANPS_WORD_RST;
		end else if (RX_PAGE_VALID && RX_PAGE_IS_BASE) begin
			lp_base_q <= RX_PAGE_WORD;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			lp_np_q <= ANPS_WORD_RST;
		end else if (RX_PAGE_VALID && !RX_PAGE_IS_BASE) begin
			lp_np_q <= RX_PAGE_WORD;
		end
	end

	// ----------------------------------------
	// latching-high expansion flags
	// ----------------------------------------

	assign exp_rd_clr = mdc_rise && state_q == ANPS_ST_TA && cnt_q == 6'h00 && op_rd_q && phy_hit
		&& addr_q[4:0] == ANPS_REG_EXP;

	assign page_rx_clr = exp_rd_clr | (ALT_NP_FEATURE & (~MR_PAGE_RX | TRANSMIT_DISABLE));

	// page received flag
	// set in the same cycle as the store, so word and flag appear together
	anps_latch_bit u_page_rx (
		.clk(CLK),
		.rst_n(RESET_N),
		.set(RX_PAGE_VALID),
		.clr(page_rx_clr),
		.q(page_rx_flag)
	);

	anps_latch_bit u_pd_fault (
		.clk(CLK),
		.rst_n(RESET_N),
		.set(PD_FAULT),
		.clr(exp_rd_clr),
		.q(pd_fault_flag)
	);

	// base page latch
	// only tracks the variable while the alternate feature is on
	anps_latch_bit u_base_page (
		.clk(CLK),
		.rst_n(RESET_N),
		.set(NEG_BASE_PAGE & ALT_NP_FEATURE),
		.clr(exp_rd_clr),
		.q(base_page_flag)
	);

	assign lp_np_able = PARTNER_AN_ABLE & lp_base_q[ANPS_PG_NEXT_PAGE];

	assign exp_word = {{ANPS_EXP_RSV_BITS{1'b0}}, base_page_flag, pd_fault_flag, lp_np_able,
		LOCAL_NP_ABLE, page_rx_flag, PARTNER_AN_ABLE};

	// ----------------------------------------
	// read multiplexer
	// ----------------------------------------

	// partner technology bits
	// bits 14..5 of the stored page cover ack, pause and technology fields; bit 15 is next page, bits 4..0 the selector
	always_comb begin
		unique case (addr_q[4:0])
			ANPS_REG_PARTNER: rd_word = lp_base_q;
			ANPS_REG_EXP: rd_word = exp_word;
			ANPS_REG_NP_RX: rd_word = lp_np_q;
			default: rd_word = ANPS_WORD_RST;
		endcase
	end

	assign phy_hit = addr_q[9:5] == PHY_ADDR;

	// ----------------------------------------
	// management clock edge detect
	// ----------------------------------------

	// serial clock is sampled as a plain synchronous input
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			mdc_q <= 1'b0;
		end else begin
			mdc_q <= MDC;
		end
	end

	assign mdc_rise = MDC & ~mdc_q;

	// ----------------------------------------
	// management frame engine
	// ----------------------------------------

	// writes ignored
	// every mapped register is read-only, so write data is dropped
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			state_q <= ANPS_ST_PRE;
			cnt_q <= 6'h00;
			op_hi_q <= 1'b0;
			op_rd_q <= 1'b0;
			addr_q <= 10'h000;
			shift_q <= ANPS_WORD_RST;
			MDIO_OUT <= 1'b0;
			MDIO_OE <= 1'b0;
		end else if (mdc_rise) begin
			unique case (state_q)
				ANPS_ST_PRE: begin
					if (MDIO_IN) begin
						cnt_q <= (cnt_q == ANPS_PRE_LEN) ? cnt_q : cnt_q + 6'h01;
					end else begin
						// first start bit after a full preamble
						if (cnt_q == ANPS_PRE_LEN) begin
							state_q <= ANPS_ST_START;
						end
						cnt_q <= 6'h00;
					end
				end
				ANPS_ST_START: begin
					state_q <= MDIO_IN ? ANPS_ST_OP : ANPS_ST_PRE;
					cnt_q <= 6'h00;
				end
				ANPS_ST_OP: begin
					if (cnt_q == 6'h00) begin
						op_hi_q <= MDIO_IN;
						cnt_q <= 6'h01;
					end else begin
						// only 10 (read) and 01 (write) are valid
						op_rd_q <= op_hi_q & ~MDIO_IN;
						state_q <= (op_hi_q ^ MDIO_IN) ? ANPS_ST_ADDR : ANPS_ST_PRE;
						cnt_q <= 6'h00;
					end
				end
				ANPS_ST_ADDR: begin
					addr_q <= {addr_q[8:0], MDIO_IN};
					if (cnt_q == ANPS_ADDR_LAST) begin
						state_q <= ANPS_ST_TA;
						cnt_q <= 6'h00;
					end else begin
						cnt_q <= cnt_q + 6'h01;
					end
				end
				ANPS_ST_TA: begin
					if (cnt_q == 6'h00) begin
						// second turnaround bit driven low, word snapped
						cnt_q <= 6'h01;
						// only a read addressed to us shows data; otherwise the output stays low
						shift_q <= (op_rd_q && phy_hit) ? rd_word : ANPS_WORD_RST;
						MDIO_OUT <= 1'b0;
						MDIO_OE <= op_rd_q & phy_hit;
					end else begin
						MDIO_OUT <= shift_q[15];
						shift_q <= {shift_q[14:0], 1'b0};
						state_q <= ANPS_ST_DATA;
						cnt_q <= 6'h00;
					end
				end
				ANPS_ST_DATA: begin
					MDIO_OUT <= shift_q[15];
					shift_q <= {shift_q[14:0], 1'b0};
					if (cnt_q == ANPS_DATA_LAST) begin
						// last bit taken by the master, let the line go
						MDIO_OE <= 1'b0;
						MDIO_OUT <= 1'b0;
						state_q <= ANPS_ST_PRE;
						cnt_q <= 6'h00;
					end else begin
						cnt_q <= cnt_q + 6'h01;
					end
				end
				default: begin
					state_q <= ANPS_ST_PRE;
					cnt_q <= 6'h00;
				end
			endcase
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);

	a_strap_pause_load: assert property ($rose(RESET_N) |-> LOCAL_PAUSE_ADV == $past(PAUSE_STRAP))
		else $error("pause advertisement not loaded from strap");

	a_strap_tech_load: assert property ($rose(RESET_N) |-> LOCAL_TECH_ADV == $past(TECH_STRAP))
		else $error("technology advertisement not loaded from strap");

	a_selector_legal: assert property (LOCAL_SELECTOR == ANPS_SEL_8023 || LOCAL_SELECTOR == ANPS_SEL_8029)
		else $error("reserved selector offered for transmit");

	a_base_page_store: assert property (RX_PAGE_VALID && RX_PAGE_IS_BASE |=>
		lp_base_q == $past(RX_PAGE_WORD) && page_rx_flag)
		else $error("base page not stored with flag");

	a_next_page_store: assert property (RX_PAGE_VALID && !RX_PAGE_IS_BASE |=>
		lp_np_q == $past(RX_PAGE_WORD) && $stable(lp_base_q))
		else $error("next page not stored apart");

	a_page_rx_clear: assert property (exp_rd_clr && !RX_PAGE_VALID |=> !page_rx_flag)
		else $error("page received not cleared by read");

	a_alt_np_clear: assert property (ALT_NP_FEATURE && TRANSMIT_DISABLE && !RX_PAGE_VALID |=>
		!page_rx_flag)
		else $error("page received kept during transmit disable");

	a_fault_hold: assert property (pd_fault_flag && !exp_rd_clr |=> pd_fault_flag)
		else $error("fault flag dropped without a read");

	a_fault_set: assert property (PD_FAULT |=> pd_fault_flag [*1])
		else $error("fault flag not set");

	a_exp_fixed: assert property (exp_word[15:6] == 10'h000 && exp_word[ANPS_EXP_LOCAL_NP] == LOCAL_NP_ABLE)
		else $error("expansion fixed bits wrong");

	// an expansion register read drives the second turnaround bit low and keeps the line driven
	a_read_drive: assert property (exp_rd_clr |=> MDIO_OE && !MDIO_OUT ##1 MDIO_OE [*1])
		else $error("read turnaround not driven low");

endmodule

/* verif/anps_link_partner.sv */
// remote link partner model handing received page words to the block
`timescale 1ns/1ns
module anps_link_partner
	import anps_pkg::*;
(
	input wire logic clk,
	output logic page_valid,
	output logic page_is_base,
	output logic [15:0] page_word
);
	// idle state until the first page arrives
	initial begin
		page_valid = 1'b0;
		page_is_base = 1'b0;
		page_word = 16'h0000;
	end

	// offer one page for a single clock, then scramble the stale word
	task send_page(input logic [15:0] w, input logic base);
		if (base && (w[4:0] == ANPS_SEL_RSV_LO || w[4:0] == ANPS_SEL_RSV_HI)) return;
		@(negedge clk);
		page_valid = 1'b1;
		page_is_base = base;
		page_word = w;
		@(negedge clk);
		page_valid = 1'b0;
		page_is_base = ~base;
		page_word = ~w;
	endtask
endmodule

/* verif/tb_autoneg_partner_ability_status.sv */
// self-checking bench for the partner ability and expansion status registers
`timescale 1ns/1ns
module tb_autoneg_partner_ability_status
	import anps_pkg::*;
;
	localparam logic [4:0] MY_PHY = 5'h0b;
	logic CLK = 1'b0;
	logic RESET_N = 1'b0;
	logic MDC = 1'b0;
	logic MDIO_IN = 1'b1;
	logic PAUSE_STRAP = 1'b0;
	logic [3:0] TECH_STRAP = 4'h0;
	logic NEG_BASE_PAGE = 1'b0;
	logic PD_FAULT = 1'b0;
	logic PARTNER_AN_ABLE = 1'b0;
	logic MR_PAGE_RX = 1'b1;
	logic TRANSMIT_DISABLE = 1'b0;
	logic ALT_NP_FEATURE = 1'b0;
	wire MDIO_OUT, MDIO_OE, LOCAL_PAUSE_ADV, RX_PAGE_VALID, RX_PAGE_IS_BASE;
	wire [3:0] LOCAL_TECH_ADV;
	wire [4:0] LOCAL_SELECTOR;
	wire [15:0] RX_PAGE_WORD;
	int bad_count = 0;
	int n_compared = 0;
	int cyc = 0;
	logic [15:0] base_w = 16'h0000;
	logic [15:0] rd;
	logic [15:0] pg [2] = '{16'hc5e1, 16'h3a42};

	anps_status_regs i_dut (.CLK(CLK), .RESET_N(RESET_N), .MDC(MDC), .MDIO_IN(MDIO_IN), .MDIO_OUT(MDIO_OUT),
		.MDIO_OE(MDIO_OE), .PHY_ADDR(MY_PHY), .PAUSE_STRAP(PAUSE_STRAP), .TECH_STRAP(TECH_STRAP),
		.LOCAL_PAUSE_ADV(LOCAL_PAUSE_ADV), .LOCAL_TECH_ADV(LOCAL_TECH_ADV), .LOCAL_SELECTOR(LOCAL_SELECTOR),
		.RX_PAGE_VALID(RX_PAGE_VALID), .RX_PAGE_IS_BASE(RX_PAGE_IS_BASE), .RX_PAGE_WORD(RX_PAGE_WORD),
		.NEG_BASE_PAGE(NEG_BASE_PAGE), .PD_FAULT(PD_FAULT), .PARTNER_AN_ABLE(PARTNER_AN_ABLE),
		.MR_PAGE_RX(MR_PAGE_RX), .TRANSMIT_DISABLE(TRANSMIT_DISABLE), .ALT_NP_FEATURE(ALT_NP_FEATURE));
	anps_link_partner i_lp (.clk(CLK), .page_valid(RX_PAGE_VALID), .page_is_base(RX_PAGE_IS_BASE),
		.page_word(RX_PAGE_WORD));

	// 50 MHz clock
	always #10 CLK = ~CLK;

	// ----------------------------------------
	// checking and closing
	// ----------------------------------------
	task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %s exp %h got %h", nm, exp, got);
		end
	endtask

	task stop_test;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// hang guard, far above the few thousand cycles the tests need
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 30000) begin
			bad_count++;
			$display("timeout");
			stop_test();
		end
	end

	// expected expansion word from the latched flags and partner state
	function automatic logic [15:0] e6(input logic pr, input logic pdf, input logic bp);
		return {10'h000, bp, pdf, PARTNER_AN_ABLE & base_w[15], ANPS_LOCAL_NP_RST, pr, PARTNER_AN_ABLE};
	endfunction

	// ----------------------------------------
	// management port tasks
	// ----------------------------------------
	// one mdc period of four clocks; o is oe and data seen before the rise
	task bitx(input logic b, output logic [1:0] o);
		@(negedge CLK);
		MDC = 1'b0;
		MDIO_IN = b;
		@(negedge CLK);
		@(negedge CLK);
		o = {MDIO_OE, MDIO_OUT};
		MDC = 1'b1;
		@(negedge CLK);
	endtask

	task mread(input logic [4:0] phy, input logic [4:0] ra, output logic [15:0] d);
		logic [1:0] o;
		logic [45:0] f;
		f = {32'hffff_ffff, 4'b0110, phy, ra};
		for (int i = 45; i >= 0; i--) bitx(f[i], o);
		bitx(1'b1, o);
		bitx(1'b1, o);
		chk("turnaround", {14'h0000, o}, {14'h0000, phy == MY_PHY, 1'b0});
		for (int i = 15; i >= 0; i--) begin
			bitx(1'b1, o);
			d[i] = o[0];
		end
		bitx(1'b1, o);
		chk("release", {14'h0000, o}, 16'h0000);
	endtask

	task mwrite(input logic [4:0] ra, input logic [15:0] w);
		logic [1:0] o;
		logic [63:0] f;
		f = {32'hffff_ffff, 4'b0101, MY_PHY, ra, 2'b10, w};
		for (int i = 63; i >= 0; i--) bitx(f[i], o);
	endtask

	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		for (int k = 0; k < 2; k++) begin
			@(negedge CLK);
			RESET_N = 1'b0;
			PAUSE_STRAP = k[0];
			TECH_STRAP = k ? 4'h5 : 4'ha;
			repeat (2) @(negedge CLK);
			RESET_N = 1'b1;
			PAUSE_STRAP = ~PAUSE_STRAP;
			TECH_STRAP = ~TECH_STRAP;
			@(negedge CLK);
			chk("pause_adv", {15'h0000, LOCAL_PAUSE_ADV}, {15'h0000, k[0]});
			chk("tech_adv", {12'h000, LOCAL_TECH_ADV}, k ? 16'h0005 : 16'h000a);
		end
		chk("selector", {11'h000, LOCAL_SELECTOR}, {11'h000, ANPS_SEL_8023});
		mread(MY_PHY, ANPS_REG_EXP, rd);
		chk("exp_reset", rd, e6(1'b0, 1'b0, 1'b0));
		$display("test reset done");
		PARTNER_AN_ABLE = 1'b1;
		for (int j = 0; j < 2; j++) begin
			i_lp.send_page(pg[j], 1'b1);
			base_w = pg[j];
			mread(MY_PHY, ANPS_REG_PARTNER, rd);
			chk("partner", rd, base_w);
			mread(MY_PHY, ANPS_REG_EXP, rd);
			chk("exp_page", rd, e6(1'b1, 1'b0, 1'b0));
			mread(MY_PHY, ANPS_REG_EXP, rd);
			chk("exp_cleared", rd, e6(1'b0, 1'b0, 1'b0));
		end
		mwrite(ANPS_REG_PARTNER, 16'h0000);
		mwrite(ANPS_REG_EXP, 16'hffff);
		mread(MY_PHY, ANPS_REG_PARTNER, rd);
		chk("partner_wr", rd, base_w);
		mread(MY_PHY, ANPS_REG_EXP, rd);
		chk("exp_wr", rd, e6(1'b0, 1'b0, 1'b0));
		mread(MY_PHY ^ 5'h01, ANPS_REG_PARTNER, rd);
		chk("other_phy", rd, 16'h0000);
		mread(MY_PHY, 5'h1f, rd);
		chk("unmapped", rd, 16'h0000);
		$display("test base page done");
		i_lp.send_page(16'h8123, 1'b0);
		mread(MY_PHY, ANPS_REG_NP_RX, rd);
		chk("next_page", rd, 16'h8123);
		mread(MY_PHY, ANPS_REG_PARTNER, rd);
		chk("partner_kept", rd, base_w);
		mread(MY_PHY, ANPS_REG_EXP, rd);
		chk("exp_np", rd, e6(1'b1, 1'b0, 1'b0));
		@(negedge CLK) PD_FAULT = 1'b1;
		@(negedge CLK) PD_FAULT = 1'b0;
		mread(MY_PHY, ANPS_REG_EXP, rd);
		chk("pd_fault", rd, e6(1'b0, 1'b1, 1'b0));
		mread(MY_PHY, ANPS_REG_EXP, rd);
		chk("pd_cleared", rd, e6(1'b0, 1'b0, 1'b0));
		for (int k = 0; k < 2; k++) begin
			ALT_NP_FEATURE = k[0];
			@(negedge CLK) NEG_BASE_PAGE = 1'b1;
			@(negedge CLK) NEG_BASE_PAGE = 1'b0;
			mread(MY_PHY, ANPS_REG_EXP, rd);
			chk("base_flag", rd, e6(1'b0, 1'b0, k[0]));
		end
		for (int k = 0; k < 2; k++) begin
			i_lp.send_page(base_w, 1'b1);
			@(negedge CLK);
			MR_PAGE_RX = k[0];
			TRANSMIT_DISABLE = k[0];
			@(negedge CLK);
			MR_PAGE_RX = 1'b1;
			TRANSMIT_DISABLE = 1'b0;
			mread(MY_PHY, ANPS_REG_EXP, rd);
			chk("alt_clear", rd, e6(1'b0, 1'b0, 1'b0));
		end
		$display("test flags done");
		stop_test();
	end
endmodule
